// ---- fantc_top.sv ----
// Top of the fan tachometer count latch: register port, tick divider, two channels.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Each channel counts internal clock ticks during one tachometer pulse into eight bits.
// - The readable count is the final count of the last complete pulse, held until the next ends.
// - After a preload write the count may be wrong for two pulses and software discards it.
// - Two independent channels each have their own readable eight-bit count register.
// - Standby supply power-on reset clears the count registers to zero.
// - A two-bit divisor per channel scales the count by 1, 2, 4 or 8, defaulting to 2.
module fantc_top (
  // Clock and standby supply power-on reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Register port
  input  wire logic [fantc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [fantc_pkg::CNT_W-1:0]   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [fantc_pkg::CNT_W-1:0]   rdata_o,
  // Fan tachometer pins
  input  wire logic                          first_fan_channel_i,
  input  wire logic                          second_fan_channel_i
);
  logic [fantc_pkg::TICK_W-1:0]           tick_cnt_r;
  logic                                   tick_r;
  logic [fantc_pkg::CNT_W-1:0]            div_reg_r;
  logic [fantc_pkg::CNT_W-1:0]            preload_r;
  logic                                   preload_wr;
  logic [fantc_pkg::NUM_CH-1:0]           tach;
  logic [fantc_pkg::NUM_CH*fantc_pkg::DIV_W-1:0] div_vec;
  fantc_pkg::fantc_stat_t                 stat [fantc_pkg::NUM_CH];
  logic [fantc_pkg::CNT_W-1:0]            rdata_nxt;

  // Internal count clock as a one-cycle enable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == fantc_pkg::TICK_W'(fantc_pkg::TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + fantc_pkg::TICK_W'(1);
      tick_r     <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg_r <= '0;
      div_reg_r[fantc_pkg::DIV_ONE_LSB +: fantc_pkg::DIV_W] <= fantc_pkg::DIV_RST;
      div_reg_r[fantc_pkg::DIV_TWO_LSB +: fantc_pkg::DIV_W] <= fantc_pkg::DIV_RST;
    end else if (wr_i && addr_i == fantc_pkg::COUNT_DIVISOR_ADR) begin
      div_reg_r <= wdata_i;
    end
  end

  // The preload value is only stored here; its write arms the settle window.
  assign preload_wr = wr_i && addr_i == fantc_pkg::PRELOAD_ADR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preload_r <= fantc_pkg::PRE_RST;
    end else if (preload_wr) begin
      preload_r <= wdata_i;
    end
  end

  assign tach    = {second_fan_channel_i, first_fan_channel_i};
  assign div_vec = {div_reg_r[fantc_pkg::DIV_TWO_LSB +: fantc_pkg::DIV_W],
                    div_reg_r[fantc_pkg::DIV_ONE_LSB +: fantc_pkg::DIV_W]};

  for (genvar g = 0; g < fantc_pkg::NUM_CH; g++) begin : g_ch
    fantc_chan u_chan (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .tick_i       (tick_r),
      .div_i        (div_vec[g*fantc_pkg::DIV_W +: fantc_pkg::DIV_W]),
      .preload_wr_i (preload_wr),
      .tach_i       (tach[g]),
      .stat_o       (stat[g])
    );
  end

  always_comb begin
    rdata_nxt = '0;
    case (addr_i)
      fantc_pkg::FAN_ONE_PULSE_COUNT_ADR: rdata_nxt = stat[0].count;
      fantc_pkg::FAN_TWO_PULSE_COUNT_ADR: rdata_nxt = stat[1].count;
      fantc_pkg::COUNT_DIVISOR_ADR:       rdata_nxt = div_reg_r;
      fantc_pkg::PRELOAD_ADR:             rdata_nxt = preload_r;
      fantc_pkg::SETTLE_STATUS_ADR:       rdata_nxt = {4'h0, stat[1].settle, stat[0].settle};
      default:                            rdata_nxt = '0;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= '0;
    end
  end

  reset_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (stat[0].count == fantc_pkg::CNT_RST && stat[1].count == fantc_pkg::CNT_RST))
    else $error("Counts not cleared by reset.");
  read_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == fantc_pkg::FAN_TWO_PULSE_COUNT_ADR) |=> rdata_o == $past(stat[1].count))
    else $error("Second channel read returned wrong count.");
  read_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == fantc_pkg::FAN_ONE_PULSE_COUNT_ADR) |=> rdata_o == $past(stat[0].count))
    else $error("First channel read returned wrong count.");
  tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_r |=> !tick_r)
    else $error("Count tick lasted more than one cycle.");
  div_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == fantc_pkg::COUNT_DIVISOR_ADR) |=> div_reg_r == $past(wdata_i))
    else $error("Divisor write did not land.");
endmodule : fantc_top
`default_nettype wire

// ---- fantc_pkg.sv ----
// Package for the fan tachometer count latch: map, fields, timing and carrier types.
`default_nettype none
package fantc_pkg;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DIV_W  = 2;
  localparam int unsigned PRE_W  = 3;
  localparam int unsigned SET_W  = 2;

  // Register map.
  localparam logic [ADDR_W-1:0] FAN_ONE_PULSE_COUNT_ADR = 8'h50;
  localparam logic [ADDR_W-1:0] FAN_TWO_PULSE_COUNT_ADR = 8'h51;
  localparam logic [ADDR_W-1:0] COUNT_DIVISOR_ADR       = 8'h52;
  localparam logic [ADDR_W-1:0] PRELOAD_ADR             = 8'h53;
  localparam logic [ADDR_W-1:0] SETTLE_STATUS_ADR       = 8'h54;

  // Divisor field positions inside the divisor register.
  localparam int unsigned DIV_ONE_LSB = 4;
  localparam int unsigned DIV_TWO_LSB = 6;

  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hFF;
  localparam logic [CNT_W-1:0] PRE_RST  = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST  = 2'h1;
  localparam logic [SET_W-1:0] SETTLE_N = 2'h2;

  // Internal count clock derived from the 200 MHz system clock.
  localparam int unsigned CLK_NS     = 5;
  localparam int unsigned INT_CLK_NS = 1000;
  localparam int unsigned TICK_CYC   = (INT_CLK_NS / CLK_NS < 1) ? 1 : INT_CLK_NS / CLK_NS;
  localparam int unsigned TICK_W     = $clog2(TICK_CYC);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [SET_W-1:0] settle;
  } fantc_stat_t;
endpackage : fantc_pkg
`default_nettype wire

// ---- fantc_chan.sv ----
// One tachometer channel: pin synchroniser, prescaled period counter and latch.
`timescale 1ns/10ps
`default_nettype none
module fantc_chan (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Timing and control
  input  wire logic                         tick_i,
  input  wire logic [fantc_pkg::DIV_W-1:0]  div_i,
  input  wire logic                         preload_wr_i,
  // Fan pin
  input  wire logic                         tach_i,
  // Status
  output var fantc_pkg::fantc_stat_t        stat_o
);
  logic                          tach_m_r;
  logic                          tach_s_r;
  logic                          tach_d_r;
  logic                          rise;
  logic [fantc_pkg::PRE_W-1:0]   pre_r;
  logic [fantc_pkg::PRE_W-1:0]   pre_lim;
  logic [fantc_pkg::CNT_W-1:0]   run_r;
  logic [fantc_pkg::CNT_W-1:0]   count_r;
  logic [fantc_pkg::SET_W-1:0]   settle_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tach_m_r <= 1'b0;
      tach_s_r <= 1'b0;
      tach_d_r <= 1'b0;
    end else begin
      tach_m_r <= tach_i;
      tach_s_r <= tach_m_r;
      tach_d_r <= tach_s_r;
    end
  end

  // One pulse is measured rising edge to rising edge of the synchronised pin.
  assign rise    = tach_s_r & ~tach_d_r;
  assign pre_lim = fantc_pkg::PRE_W'((1 << div_i) - 1);

  // The prescaler slows the count so slower fans still fit into eight bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= '0;
      run_r <= fantc_pkg::CNT_RST;
    end else if (rise) begin
      pre_r <= '0;
      run_r <= fantc_pkg::CNT_RST;
    end else if (tick_i) begin
      if (pre_r >= pre_lim) begin
        pre_r <= '0;
        if (run_r != fantc_pkg::CNT_MAX) begin
          run_r <= run_r + 8'h01;
        end
      end else begin
        pre_r <= pre_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= fantc_pkg::CNT_RST;
    end else if (rise) begin
      count_r <= run_r;
    end
  end

  // A preload write in the same cycle as a pulse edge restarts the settle window.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_r <= '0;
    end else if (preload_wr_i) begin
      settle_r <= fantc_pkg::SETTLE_N;
    end else if (rise && settle_r != '0) begin
      settle_r <= settle_r - 2'h1;
    end
  end

  assign stat_o = {count_r, settle_r};

  latch_final_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise |=> count_r == $past(run_r))
    else $error("Count not latched at pulse end.");
  latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rise |=> $stable(count_r))
    else $error("Latched count changed mid pulse.");
  count_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_r == fantc_pkg::CNT_MAX && !rise) |=> run_r == fantc_pkg::CNT_MAX)
    else $error("Running count wrapped.");
  div_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_i && !rise && pre_r < pre_lim) |=> $stable(run_r))
    else $error("Count advanced before divisor elapsed.");
  settle_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    preload_wr_i |=> settle_r == fantc_pkg::SETTLE_N)
    else $error("Settle window not armed by preload write.");
  settle_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!preload_wr_i && rise && settle_r != '0) |=> settle_r == $past(settle_r) - 2'h1)
    else $error("Settle window not counted down by a pulse.");
endmodule : fantc_chan
`default_nettype wire

// ---- fantc_fan_model.sv ----
// Behavioural fan tachometer: a square wave with a programmable half period.
`timescale 1ns/10ps
`default_nettype none
module fantc_fan_model (
  // Control
  input  wire logic        en_i,
  input  wire logic [31:0] half_ns_i,
  // Tachometer pin
  output logic             tach_o
);
  // A stopped fan parks its pin low, so the block sees no edge at all.
  always begin
    // An unknown enable at time zero must park the pin, not start a pulse.
    if (en_i !== 1'h1) begin
      tach_o = 1'h0;
      @(posedge en_i);
    end else begin
      tach_o = 1'h1;
      #(half_ns_i);
      tach_o = 1'h0;
      #(half_ns_i);
    end
  end
endmodule : fantc_fan_model
`default_nettype wire

// ---- fantc_top_tb_top.sv ----
// Self-checking bench for the fan tachometer count latch.
`timescale 1ns/10ps
`default_nettype none
module fantc_top_tb_top;
  localparam logic [7:0] A1 = fantc_pkg::FAN_ONE_PULSE_COUNT_ADR;
  localparam logic [7:0] A2 = fantc_pkg::FAN_TWO_PULSE_COUNT_ADR;
  localparam logic [7:0] AD = fantc_pkg::COUNT_DIVISOR_ADR;
  localparam logic [7:0] AS = fantc_pkg::SETTLE_STATUS_ADR;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'h0;
  logic        rd_i = 1'h0;
  logic [7:0]  rdata_o;
  logic        f1;
  logic        f2;
  logic        en1 = 1'h0;
  logic        en2 = 1'h0;
  logic [31:0] h1 = 32'h0000_1000;
  logic [31:0] h2 = 32'h0002_49F0;
  logic [7:0]  v;
  int          errors = 0;
  int          comparisons = 0;
  int          k;

  always #2.5 clk_i = ~clk_i;

  fantc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .first_fan_channel_i(f1),
    .second_fan_channel_i(f2));
  fantc_fan_model first_fan_channel (.en_i(en1), .half_ns_i(h1), .tach_o(f1));
  fantc_fan_model second_fan_channel (.en_i(en2), .half_ns_i(h2), .tach_o(f2));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 v = rdata_o;
  endtask : rd

  // Bounded wait for n rising edges on one fan pin, then room for the latch.
  task automatic rises(input bit two, input int n);
    int c;
    logic p;
    c = 0;
    p = two ? f2 : f1;
    for (int t = 0; t < 70000 && c < n; t++) begin
      @(posedge clk_i);
      if ((two ? f2 : f1) && !p)
        c++;
      p = two ? f2 : f1;
    end
    if (c < n) begin
      errors++;
      final_report();
    end
    repeat (10) @(posedge clk_i);
  endtask : rises

  // The free-running tick costs one count of phase error only when nothing divides it.
  function automatic logic [7:0] in_win(input logic [7:0] s, input int d, input int n);
    return {7'h00, s == n || (d == 0 && s == n + 1)};
  endfunction : in_win

  initial begin
    void'($urandom(32'h2316));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(A1);
    chk("fan one count", v, 8'h00);
    rd(A2);
    chk("fan two count", v, 8'h00);
    rd(AD);
    chk("divisor", v, 8'h50);
    wr(A1, 8'hA5);
    rd(A1);
    chk("read only count", v, 8'h00);
    rd(8'h7F);
    chk("unmapped", v, 8'h00);
    wr(fantc_pkg::PRELOAD_ADR, 8'h3C);
    rd(AS);
    chk("settle", v, 8'h0A);
    rd(fantc_pkg::PRELOAD_ADR);
    chk("preload", v, 8'h3C);
    wr(AD, 8'h05);
    en2 <= 1'h1;
    en1 <= 1'h1;
    for (int d = 0; d < 4; d++) begin
      k = 2 + $urandom_range(3);
      wr(AD, {2'h0, 2'(d), 4'h5});
      rd(AD);
      chk("divisor", v, {2'h0, 2'(d), 4'h5});
      h1 <= 32'((k * (1 << d) * 1000 + 500) / 2);
      rises(1'h0, 3);
      rd(A1);
      chk("fan one count", in_win(v, d, k), 8'h01);
      repeat (200) @(posedge clk_i);
      rd(A1);
      chk("held count", in_win(v, d, k), 8'h01);
      if (d == 0) begin
        rd(AS);
        chk("settle one", {6'h00, v[1:0]}, 8'h00);
      end
    end
    rises(1'h1, 1);
    rd(A2);
    chk("fan two saturated", v, 8'hFF);
    rd(AS);
    chk("settle done", v, 8'h00);
    final_report();
  end
endmodule : fantc_top_tb_top
`default_nettype wire
